//--- logic/iewc_cfg.svh
// constants for the interrupt entry, wake and context unit
`ifndef IEWC_CFG_SVH
`define IEWC_CFG_SVH
`define IEWC_VECTOR        15'h0004
`define IEWC_SHADOW_BANK   5'h1F
`define IEWC_SH_ACC        3'h4
`define IEWC_SH_STATUS     3'h5
`define IEWC_SH_BANK       3'h6
`define IEWC_SH_PC_HIGH_LATCH     3'h7
`define IEWC_SH_FSR0L      3'h0
`define IEWC_SH_FSR0H      3'h1
`define IEWC_SH_FSR1L      3'h2
`define IEWC_SH_FSR1H      3'h3
`define IEWC_STAT_WDT_BIT  4
`define IEWC_STAT_PD_BIT   3
`define IEWC_STAT_KEEP     8'hE7
`define IEWC_FLUSH_CYCLES  2'h2
`define IEWC_NUM_SRC       4
`endif

//--- logic/iewc_pkg.sv
// types for the interrupt entry, wake and context unit
package iewc_pkg;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] status;
    logic [4:0] bank;
    logic [7:0] pc_high_latch;
    logic [31:0] indirect_pointer_regs;
  } iewc_ctx_t;
  typedef enum logic [2:0] {
    IEWC_RUN, IEWC_FLUSH, IEWC_VEC, IEWC_SLEEP, IEWC_WAKE
  } iewc_state_t;
endpackage

//--- logic/iewc_shadow_mem.sv
// shadow register store: eight bytes, registered read data
`timescale 1ns/10ps
module iewc_shadow_mem (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // software port
  input  wire logic [2:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // bulk save
  input  wire logic       save_i,
  input  wire logic [63:0] save_data_i,
  output logic      [63:0] all_o
);
  logic [7:0] mem [8];

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          mem[g] <= 8'h00;
        end else if (save_i) begin
          mem[g] <= save_data_i[g*8 +: 8];
        end else if (wr_i && addr_i == 3'(g)) begin
          mem[g] <= wdata_i;
        end
      end
      assign all_o[g*8 +: 8] = mem[g];
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem[addr_i];
    end
  end
endmodule

//--- logic/iewc_top.sv
// interrupt entry, sleep wake and automatic context save/restore
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "iewc_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1: synchronous source reaches vector code three or four cycles after event.
// RULE2: asynchronous source reaches vector code within three to five cycles.
// RULE3: pin flag may set anywhere in the Q4-Q1 span.
// RULE4: only sources running without system clock may wake from sleep.
// RULE5: wake only for sources enabled before sleep was entered.
// RULE6: on wake branch to vector if global enable, else continue.
// RULE7: instruction after sleep always executes before branching to handler.
// RULE8: external pin gives asynchronous edge-triggered request, gated by its enable.
// RULE9: edge select one picks rising edge, zero picks falling edge.
// RULE10: valid pin edge sets the pin flag.
// RULE11: pin flag with global and pin enables redirects to vector.
// RULE12: entry pushes the return program counter onto the stack.
// RULE13: entry copies accumulator, status less two bits, bank, pointers, high latch.
// RULE14: return reloads all saved registers from shadows, overriding handler changes.
// RULE15: software writes to shadows become the restored values.
// RULE16: shadows sit in bank 31, readable and writable.
// RULE17: acceptance flushes prefetch, clears global enable, pushes, saves, vectors.
// RULE18: return pops address, restores context, sets global enable.
// RULE19: flags set on events regardless of any enable.
// RULE20: every reset leaves all interrupts disabled.
module iewc_top (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  // instruction cycle from the sequencer (q1 phase pulse)
  input  wire logic                  q1_i,
  input  wire logic                  q4_i,
  input  wire logic                  multi_cycle_i,
  input  wire logic                  sleep_instr_i,
  input  wire logic                  ret_instr_i,
  input  wire logic [14:0]           pc_i,
  // external pin and its controls
  input  wire logic                  ext_pin_i,
  input  wire logic                  ext_edge_select_i,
  // peripheral sources
  input  wire logic [`IEWC_NUM_SRC-1:0] src_event_i,
  input  wire logic [`IEWC_NUM_SRC-1:0] src_enable_i,
  input  wire logic [`IEWC_NUM_SRC-1:0] src_async_i,
  input  wire logic [`IEWC_NUM_SRC-1:0] src_flag_clr_i,
  // irq control register port
  input  wire logic                  ctl_wr_i,
  input  wire logic [7:0]            ctl_wdata_i,
  output logic      [7:0]            irq_control_reg_o,
  // live core context
  input  wire iewc_pkg::iewc_ctx_t   ctx_i,
  // banked data port for shadows
  input  wire logic [4:0]            bank_i,
  input  wire logic [2:0]            dat_addr_i,
  input  wire logic                  dat_wr_i,
  input  wire logic                  dat_rd_i,
  input  wire logic [7:0]            dat_wdata_i,
  output logic      [7:0]            dat_rdata_o,
  // core control outputs
  output logic                       flush_o,
  output logic                       push_o,
  output logic      [14:0]           push_pc_o,
  output logic                       pop_o,
  output logic                       vector_load_o,
  output logic      [14:0]           vector_o,
  output logic                       restore_o,
  output iewc_pkg::iewc_ctx_t        restore_ctx_o,
  output logic                       wake_o,
  output logic                       sleeping_o,
  output logic      [`IEWC_NUM_SRC-1:0] src_flag_o
);
  logic                     global_irq_enable;
  logic                     periph_group_enable;
  logic                     ext_pin_irq_enable;
  logic                     ext_pin_irq_flag;
  logic                     pin_s1;
  logic                     pin_s2;
  logic                     pin_s3;
  logic                     edge_seen;
  logic [`IEWC_NUM_SRC-1:0] src_flag;
  logic [`IEWC_NUM_SRC-1:0] en_at_sleep;
  logic                     pending;
  logic                     wake_req;
  logic                     pend_sync;
  logic [1:0]               flush_cnt;
  logic                     dat_sel;
  logic                     dat_rd_q;
  logic [7:0]               sh_rdata;
  logic [63:0]              sh_all;
  logic [63:0]              sh_save;
  logic [7:0]               status_masked;
  iewc_pkg::iewc_state_t    state;

  //////////////////////////////////////////////////////////////////////////////
  // external pin
  // two flops before any logic, third for edge compare
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= ext_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // RULE9: edge polarity select
  // RULE8: asynchronous edge detect
  assign edge_seen = ext_edge_select_i ? (pin_s2 & ~pin_s3) : (~pin_s2 & pin_s3);

  //////////////////////////////////////////////////////////////////////////////
  // control register bits
  assign dat_sel = (bank_i == `IEWC_SHADOW_BANK);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      // RULE20: reset disables interrupts
      global_irq_enable   <= 1'b0;
      periph_group_enable <= 1'b0;
      ext_pin_irq_enable  <= 1'b0;
    end else begin
      if (ctl_wr_i) begin
        periph_group_enable <= ctl_wdata_i[6];
        ext_pin_irq_enable  <= ctl_wdata_i[4];
      end
      if (state == iewc_pkg::IEWC_FLUSH && flush_cnt == 2'h0) begin
        // RULE17: entry clears global enable
        global_irq_enable <= 1'b0;
      end else if (ret_instr_i && q1_i) begin
        // RULE18: return sets global enable
        global_irq_enable <= 1'b1;
      end else if (ctl_wr_i) begin
        global_irq_enable <= ctl_wdata_i[7];
      end
    end
  end

  // flag: set wins over software clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ext_pin_irq_flag <= 1'b0;
    end else if (edge_seen) begin
      // RULE10: edge sets flag
      // RULE3: set at any phase, Q4-Q1 included
      // RULE19: set regardless of enables
      ext_pin_irq_flag <= 1'b1;
    end else if (ctl_wr_i) begin
      ext_pin_irq_flag <= ctl_wdata_i[1];
    end
  end

  genvar s;
  generate
    for (s = 0; s < `IEWC_NUM_SRC; s++) begin : g_src
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          src_flag[s] <= 1'b0;
        end else if (src_event_i[s]) begin
          // RULE19: flag ignores enables
          src_flag[s] <= 1'b1;
        end else if (src_flag_clr_i[s]) begin
          src_flag[s] <= 1'b0;
        end
      end
    end
  endgenerate

  assign src_flag_o = src_flag;
  assign irq_control_reg_o = {global_irq_enable, periph_group_enable, 1'b0,
                              ext_pin_irq_enable, 2'b00, ext_pin_irq_flag, 1'b0};

  //////////////////////////////////////////////////////////////////////////////
  // request combine
  // RULE11: pin flag with its enable
  assign pending = (ext_pin_irq_flag & ext_pin_irq_enable)
                 | (periph_group_enable & |(src_flag & src_enable_i));

  // RULE4: clock-free sources only
  // RULE5: enables captured at sleep entry
  assign wake_req = (ext_pin_irq_flag & ext_pin_irq_enable)
                  | |(src_flag & en_at_sleep & src_async_i);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      en_at_sleep <= '0;
    end else if (state == iewc_pkg::IEWC_RUN && sleep_instr_i && q1_i) begin
      en_at_sleep <= src_enable_i;
    end
  end

  // sampled once per instruction cycle at q1; async arrival adds a cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pend_sync <= 1'b0;
    end else if (q1_i) begin
      pend_sync <= pending & global_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // entry sequencer
  // two nop cycles, then vector, gives 3-4 cycles sync and 3-5 async
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state     <= iewc_pkg::IEWC_RUN;
      flush_cnt <= 2'h0;
    end else begin
      unique case (state)
        iewc_pkg::IEWC_RUN: begin
          if (sleep_instr_i && q1_i) begin
            state <= iewc_pkg::IEWC_SLEEP;
          end else if (pend_sync && q1_i && !multi_cycle_i) begin
            // RULE1: sync latency start
            // RULE2: async adds sampling cycle
            state     <= iewc_pkg::IEWC_FLUSH;
            flush_cnt <= 2'h0;
          end
        end
        iewc_pkg::IEWC_FLUSH: begin
          if (q1_i) begin
            if (flush_cnt == `IEWC_FLUSH_CYCLES - 2'h1) begin
              state <= iewc_pkg::IEWC_VEC;
            end
            flush_cnt <= flush_cnt + 2'h1;
          end
        end
        iewc_pkg::IEWC_VEC: begin
          state <= iewc_pkg::IEWC_RUN;
        end
        iewc_pkg::IEWC_SLEEP: begin
          if (wake_req) begin
            state <= iewc_pkg::IEWC_WAKE;
          end
        end
        iewc_pkg::IEWC_WAKE: begin
          // RULE7: next instruction runs first
          // RULE6: vector only with global enable
          if (q4_i) begin
            state <= iewc_pkg::IEWC_RUN;
          end
        end
      endcase
    end
  end

  assign sleeping_o    = (state == iewc_pkg::IEWC_SLEEP);
  assign wake_o        = (state == iewc_pkg::IEWC_SLEEP) && wake_req;
  // RULE17: flush prefetch during nops
  assign flush_o       = (state == iewc_pkg::IEWC_FLUSH);
  // RULE12: push return address
  assign push_o        = (state == iewc_pkg::IEWC_FLUSH) && (flush_cnt == 2'h0) && q1_i;
  assign vector_load_o = (state == iewc_pkg::IEWC_VEC);
  assign vector_o      = `IEWC_VECTOR;
  // RULE18: pop on return
  assign pop_o         = ret_instr_i && q1_i;
  assign restore_o     = pop_o;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      push_pc_o <= 15'h0000;
    end else if (state == iewc_pkg::IEWC_RUN && q1_i) begin
      push_pc_o <= pc_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // context shadows
  // RULE13: status without two flag bits
  assign status_masked = ctx_i.status & `IEWC_STAT_KEEP;
  assign sh_save = {ctx_i.pc_high_latch, 3'b000, ctx_i.bank, status_masked, ctx_i.acc,
                    ctx_i.indirect_pointer_regs};

  // RULE16: bank 31 software access
  iewc_shadow_mem u_shadow (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .addr_i      (dat_addr_i),
    .wr_i        (dat_wr_i && dat_sel),
    .wdata_i     (dat_wdata_i),
    .rdata_o     (sh_rdata),
    .save_i      (push_o),
    .save_data_i (sh_save),
    .all_o       (sh_all)
  );

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dat_rd_q <= 1'b0;
    end else begin
      dat_rd_q <= dat_rd_i && dat_sel;
    end
  end
  assign dat_rdata_o = dat_rd_q ? sh_rdata : 8'h00;

  // RULE14: restore overrides live values
  // RULE15: shadow writes are what restore
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      restore_ctx_o <= '0;
    end else begin
      restore_ctx_o.indirect_pointer_regs    <= sh_all[31:0];
      restore_ctx_o.acc    <= sh_all[39:32];
      restore_ctx_o.status <= sh_all[47:40];
      restore_ctx_o.bank   <= sh_all[52:48];
      restore_ctx_o.pc_high_latch <= sh_all[63:56];
    end
  end
endmodule

//--- dv/iewc_props.sv
// assertion checker for the interrupt entry unit
`timescale 1ns/10ps
`include "iewc_cfg.svh"
module iewc_props (
  // watched ports
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       q1_i,
  input wire logic       ret_instr_i,
  input wire logic       ext_pin_i,
  input wire logic       ext_edge_select_i,
  input wire logic       ctl_wr_i,
  input wire logic       dat_rd_i,
  input wire logic [3:0] src_event_i,
  input wire logic [3:0] src_flag_o,
  input wire logic [7:0] irq_control_reg_o,
  input wire logic [7:0] dat_rdata_o,
  input wire logic       flush_o,
  input wire logic       push_o,
  input wire logic       pop_o,
  input wire logic       restore_o,
  input wire logic       vector_load_o,
  input wire logic [14:0] vector_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_vector_fixed: assert property (vector_o == `IEWC_VECTOR)
    else $error("vector address wrong");
  a_pop_restore_pair: assert property ((pop_o == (ret_instr_i && q1_i)) && restore_o == pop_o)
    else $error("pop and restore not paired");
  a_ret_sets_global: assert property (pop_o && !ctl_wr_i |-> ##[0:1] irq_control_reg_o[7])
    else $error("return left global enable clear");
  a_vec_clears_global: assert property (vector_load_o |-> !irq_control_reg_o[7])
    else $error("global enable set at vector load");
  a_flush_before_vec: assert property (vector_load_o |-> $past(flush_o))
    else $error("vector load without flush");
  a_push_to_vec: assert property (push_o |-> ##[1:12] vector_load_o)
    else $error("push not followed by vector load");
  a_reset_clears_all: assert property ($fell(reset_i) |-> irq_control_reg_o == 8'h00)
    else $error("control bits not clear after reset");
  a_event_sets_flag: assert property (|src_event_i |=>
    (src_flag_o & $past(src_event_i)) == $past(src_event_i))
    else $error("event did not set its flag");
  // sync flops plus flag register give the slack
  a_edge_sets_flag: assert property ((ext_edge_select_i ? $rose(ext_pin_i) : $fell(ext_pin_i))
    && !ctl_wr_i |-> ##[2:5] irq_control_reg_o[1])
    else $error("pin edge did not set flag");
  a_read_idle_zero: assert property (!$past(dat_rd_i) |-> dat_rdata_o == 8'h00)
    else $error("read data outside read slot");
  c_vector: cover property (vector_load_o);
  c_return: cover property (pop_o);
  c_pin_flag: cover property ($rose(irq_control_reg_o[1]));
endmodule

//--- dv/iewc_seq_model.sv
// sequencer model: quarter phases, program counter, return stack
`timescale 1ns/10ps
module iewc_seq_model (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // from the unit
  input  wire logic        push_i,
  input  wire logic [14:0] push_pc_i,
  input  wire logic        pop_i,
  input  wire logic        vector_load_i,
  input  wire logic [14:0] vector_i,
  // to the unit and bench
  output logic             q1_o,
  output logic             q4_o,
  output logic      [14:0] pc_o,
  output logic      [14:0] stack_top_o
);
  logic [1:0] phase;
  always_ff @(posedge sys_clk_i) begin
    phase <= reset_i ? 2'h0 : phase + 2'h1;
    q1_o  <= !reset_i && phase == 2'h3;
    q4_o  <= !reset_i && phase == 2'h2;
  end
  // pc held still so the pushed value is known
  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      pc_o <= 15'h0123;
    else if (vector_load_i)
      pc_o <= vector_i;
    else if (pop_i)
      pc_o <= stack_top_o;
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      stack_top_o <= 15'h0000;
    else if (push_i)
      stack_top_o <= push_pc_i;
  end
endmodule

//--- dv/iewc_top_tb.sv
// self-checking bench for the interrupt entry unit
`timescale 1ns/10ps
`include "iewc_cfg.svh"
module iewc_top_tb;
  logic        sys_clk = 1'b0, reset = 1'b1, slp_in = 1'b0, ret_in = 1'b0;
  logic        pin = 1'b0, sel = 1'b0, ctl_wr = 1'b0, dwr = 1'b0, drd = 1'b0;
  logic [3:0]  ev = 4'h0, en = 4'h0, asy = 4'h0, flags;
  logic [7:0]  ctl_wd = 8'h00, dwd = 8'h00, ctl, rdat;
  logic [2:0]  dadr = 3'h0;
  logic [14:0] pc, ppc, vec, stk;
  logic        q1, q4, flush, push, pop, vld, rest, wake, slp;
  iewc_pkg::iewc_ctx_t ctx = '0, rctx;
  int          error_cnt = 0, checks = 0, cyc = 0;
  iewc_top dut (.sys_clk_i(sys_clk), .reset_i(reset), .q1_i(q1), .q4_i(q4),
    .multi_cycle_i(1'b0), .sleep_instr_i(slp_in), .ret_instr_i(ret_in), .pc_i(pc),
    .ext_pin_i(pin), .ext_edge_select_i(sel), .src_event_i(ev), .src_enable_i(en),
    .src_async_i(asy), .src_flag_clr_i(4'h0), .ctl_wr_i(ctl_wr), .ctl_wdata_i(ctl_wd),
    .irq_control_reg_o(ctl), .ctx_i(ctx), .bank_i(`IEWC_SHADOW_BANK), .dat_addr_i(dadr),
    .dat_wr_i(dwr), .dat_rd_i(drd), .dat_wdata_i(dwd), .dat_rdata_o(rdat),
    .flush_o(flush), .push_o(push), .push_pc_o(ppc), .pop_o(pop), .vector_load_o(vld),
    .vector_o(vec), .restore_o(rest), .restore_ctx_o(rctx), .wake_o(wake),
    .sleeping_o(slp), .src_flag_o(flags));
  iewc_seq_model seq (.sys_clk_i(sys_clk), .reset_i(reset), .push_i(push), .push_pc_i(ppc),
    .pop_i(pop), .vector_load_i(vld), .vector_i(vec), .q1_o(q1), .q4_o(q4), .pc_o(pc),
    .stack_top_o(stk));
  initial forever #2.5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ctl_write(input logic [7:0] v);
    ctl_wr <= 1'b1;
    ctl_wd <= v;
    @(posedge sys_clk);
    ctl_wr <= 1'b0;
  endtask
  task automatic sh_write(input logic [2:0] a, input logic [7:0] v);
    dwr <= 1'b1;
    dadr <= a;
    dwd <= v;
    @(posedge sys_clk);
    dwr <= 1'b0;
  endtask
  task automatic sh_read(input logic [2:0] a, input logic [7:0] exp);
    drd <= 1'b1;
    dadr <= a;
    @(posedge sys_clk);
    drd <= 1'b0;
    @(negedge sys_clk);
    check(rdat, exp);
    @(posedge sys_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_entry(input logic s);
    int n;
    sel <= s;
    pin <= ~s;
    ctx <= {8'ha5, 8'hff, 5'h0b, 8'h3c, 32'h1234_5678};
    repeat (8) @(posedge sys_clk);
    ctl_write(8'h90);
    pin <= s;
    n = 0;
    while (vld !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(n >= 12 && n <= 21, 1'b1);
    check(ctl, 8'h12);
    check(stk, 15'h0123);
    sh_read(3'h4, 8'ha5);
    sh_read(3'h5, 8'he7);
    sh_read(3'h7, 8'h3c);
    sh_read(3'h0, 8'h78);
    // flag cleared in the handler, or return re-enters at once
    ctl_write(8'h10);
    ctx <= '0;
    sh_write(3'h4, 8'h5a);
    ret_in <= 1'b1;
    n = 0;
    @(negedge sys_clk);
    while (pop !== 1'b1 && n < 12) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    ret_in <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(rctx.acc, 8'h5a);
    check(rctx.pc_high_latch, 8'h3c);
    check(pc, 15'h0123);
    check(ctl, 8'h90);
    $display("entry test done, edge select %0d", s);
  endtask
  task automatic t_refused();
    int n;
    ctl_write(8'h10);
    pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pin <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      n += vld;
    end
    check(n, 0);
    check(ctl, 8'h12);
    ctl_write(8'h00);
    $display("refused entry test done");
  endtask
  task automatic t_sleep();
    int n;
    ctl_write(8'h40);
    en <= 4'h3;
    asy <= 4'h5;
    slp_in <= 1'b1;
    n = 0;
    while (slp !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      n++;
    end
    slp_in <= 1'b0;
    ev <= 4'h6;
    n = 0;
    repeat (12) begin
      @(posedge sys_clk);
      ev <= 4'h0;
      n += wake;
    end
    check(n, 0);
    check(flags, 4'h6);
    ev <= 4'h1;
    n = 0;
    repeat (12) begin
      @(posedge sys_clk);
      ev <= 4'h0;
      n += wake + vld;
    end
    check(n != 0, 1'b1);
    repeat (30) begin
      @(posedge sys_clk);
      n += vld;
    end
    check(n, 32'h1);
    $display("sleep wake test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    check(ctl, 8'h00);
    t_entry(1'b1);
    t_entry(1'b0);
    t_refused();
    t_sleep();
    give_verdict();
  end
endmodule
bind iewc_top iewc_props u_props (.sys_clk_i, .reset_i, .q1_i, .ret_instr_i, .ext_pin_i,
  .ext_edge_select_i, .ctl_wr_i, .dat_rd_i, .src_event_i, .src_flag_o, .irq_control_reg_o,
  .dat_rdata_o, .flush_o, .push_o, .pop_o, .restore_o, .vector_load_o, .vector_o);
